// file: hdl/clch_card.sv
`timescale 1ns/100ps
`include "clch_defs.svh"
// Operation
// - Terminal ends transaction on disallowed status
// - 9000 or 61xx both mean success
// - Script warnings continue with next command
// - Reserved bits always sent as zero
// - One logical channel, one active application
// - Lifecycle commands only in secure scripts
// - Blocked application answers SELECT with 6283
// - Invalidated application gives only declined cryptogram
// - Application block: CLA 8C/84, INS 1E
// - Application unblock: CLA 8C/84, INS 18
// - Card block: CLA 8C/84, INS 16
// - Data field is checked message auth code
// - Lifecycle responses carry status bytes only
// - Application block answers 9000 even repeated
// - Unblock clears invalidated state of application
// - Unblock answers 9000 whether invalidated or not
// - Card block disables all applications permanently
// - Blocked card answers SELECT 6A81, nothing else
// - 6300 means issuer authentication failed
module clch_card #(
  parameter int APP_COUNT = 4
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  clch_if.card link,
  input wire logic [$clog2(APP_COUNT)-1:0] select_app_in,
  input wire logic [APP_COUNT-1:0] nv_app_inval_in,
  input wire logic nv_card_blocked_in,
  input wire logic nv_load_in,
  input wire logic [1:0] gen_ac_type_in,
  input wire logic auth_ok_in,
  output logic [APP_COUNT-1:0] app_inval_out,
  output logic card_blocked_out,
  output logic [$clog2(APP_COUNT)-1:0] active_app_out,
  output logic nv_write_out
);
  localparam int AW = $clog2(APP_COUNT);

  logic [APP_COUNT-1:0] app_inval;
  logic card_blocked;
  logic [AW-1:0] active_app;
  logic rsp_valid;
  logic [15:0] sw;
  logic [7:0] cid;
  logic nv_write;
  logic [15:0] next_sw;
  logic [7:0] next_cid;
  logic [APP_COUNT-1:0] next_app_inval;
  logic next_card_blocked;
  logic [AW-1:0] next_active_app;
  logic next_nv_write;

  // Decode helpers shared by all lifecycle commands
  function automatic logic sm_cla(input logic [7:0] c);
    sm_cla = (c == `CLCH_CLA_SM_MAC) || (c == `CLCH_CLA_SM_ALT);
  endfunction
  function automatic logic p_zero(input logic [7:0] a, input logic [7:0] b);
    p_zero = (a == `CLCH_P_ZERO) && (b == `CLCH_P_ZERO);
  endfunction

  // Command classification
  wire logic take = link.cmd_valid;
  wire logic is_app_block = (link.ins == `CLCH_INS_APP_BLOCK);
  wire logic is_app_unblock = (link.ins == `CLCH_INS_APP_UNBLOCK);
  wire logic is_card_block = (link.ins == `CLCH_INS_CARD_BLOCK);
  wire logic is_lc_ins = is_app_block || is_app_unblock || is_card_block;
  wire logic is_select = (link.ins == `CLCH_INS_SELECT);
  wire logic is_gen_ac = (link.ins == `CLCH_INS_GEN_AC);
  wire logic is_ext_auth = (link.ins == `CLCH_INS_EXT_AUTH);
  wire logic cur_inval = app_inval[active_app];
  wire logic sel_inval = app_inval[select_app_in];

  // force declined type on an invalidated application
  wire logic [1:0] gac_type = cur_inval ? `CLCH_CT_DECLINED : gen_ac_type_in;
  wire logic [7:0] gac_cid = {gac_type, 6'b00_0000};
  // Cryptogram info stands until the next response clears it
  wire logic [7:0] hold_cid = take ? 8'h00 : cid;

  assign link.cmd_ready = 1'b1;
  assign link.rsp_valid = rsp_valid;
  assign link.sw = sw;
  assign link.cid = cid;
  assign link.rsp_has_data = 1'b0;
  assign app_inval_out = app_inval;
  assign card_blocked_out = card_blocked;
  assign active_app_out = active_app;
  assign nv_write_out = nv_write;

  // Next state of the command interpreter
  always_comb begin
    next_sw = sw;
    next_cid = hold_cid;
    next_app_inval = app_inval;
    next_card_blocked = card_blocked;
    next_active_app = active_app;
    next_nv_write = 1'b0;
    if (take && is_lc_ins) begin
      if (!sm_cla(link.cla)) begin
        next_sw = `CLCH_SW_BAD_CLA;
      end else if (!p_zero(link.p1, link.p2)) begin
        next_sw = `CLCH_SW_BAD_P1P2;
      end else if (!link.mac_ok) begin
        next_sw = `CLCH_SW_SEC_FAIL;
      end else begin
        next_nv_write = 1'b1;
        next_sw = `CLCH_SW_OK;
        case (link.ins)
          `CLCH_INS_APP_BLOCK: begin
            next_app_inval[active_app] = 1'b1;
          end
          `CLCH_INS_APP_UNBLOCK: begin
            next_app_inval[active_app] = 1'b0;
          end
          `CLCH_INS_CARD_BLOCK: begin
            next_card_blocked = 1'b1;
          end
          default: begin
            next_nv_write = 1'b0;
          end
        endcase
      end
    end else if (take && is_select) begin
      if (card_blocked) begin
        next_sw = `CLCH_SW_NOT_SUPP;
      end else begin
        next_active_app = select_app_in;
        next_sw = sel_inval ? `CLCH_SW_INVALIDATED : `CLCH_SW_OK;
      end
    end else if (take && is_gen_ac) begin
      if (card_blocked) begin
        next_sw = `CLCH_SW_NOT_SUPP;
      end else begin
        next_sw = `CLCH_SW_OK;
        next_cid = gac_cid;
      end
    end else if (take && is_ext_auth) begin
      next_sw = auth_ok_in ? `CLCH_SW_OK : `CLCH_SW_AUTH_FAIL;
    end else if (take) begin
      next_sw = `CLCH_SW_BAD_INS;
    end
  end

  // Lifecycle flags, reloaded from storage or following commands
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      app_inval <= {APP_COUNT{`CLCH_RST_FLAGS}};
      card_blocked <= `CLCH_RST_FLAGS;
    end else if (nv_load_in) begin
      app_inval <= nv_app_inval_in;
      card_blocked <= nv_card_blocked_in;
    end else begin
      app_inval <= next_app_inval;
      card_blocked <= next_card_blocked;
    end
  end

  // Selected application, held while flags load
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_app <= '0;
    end else if (!nv_load_in) begin
      active_app <= next_active_app;
    end
  end

  // Answer strobe one cycle after a command taken while flags are not loading
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= take && !nv_load_in;
    end
  end

  // Status and cryptogram info, held while flags load
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sw <= 16'h0000;
      cid <= 8'h00;
    end else if (!nv_load_in) begin
      sw <= next_sw;
      cid <= next_cid;
    end
  end

  // Persist strobe after a successful lifecycle command
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_write <= 1'b0;
    end else begin
      nv_write <= next_nv_write && !nv_load_in;
    end
  end
endmodule // clch_card

// file: hdl/clch_defs.svh
`ifndef CLCH_DEFS_SVH
`define CLCH_DEFS_SVH
// Class bytes with and without secure messaging
`define CLCH_CLA_SM_MAC 8'h8C
`define CLCH_CLA_SM_ALT 8'h84
`define CLCH_CLA_PLAIN 8'h00
`define CLCH_CLA_PROP 8'h80
// Instruction bytes
`define CLCH_INS_APP_BLOCK 8'h1E
`define CLCH_INS_APP_UNBLOCK 8'h18
`define CLCH_INS_CARD_BLOCK 8'h16
`define CLCH_INS_SELECT 8'hA4
`define CLCH_INS_GEN_AC 8'hAE
`define CLCH_INS_EXT_AUTH 8'h82
`define CLCH_P_ZERO 8'h00
// Status words
`define CLCH_SW_OK 16'h9000
`define CLCH_SW_INVALIDATED 16'h6283
`define CLCH_SW_NOT_SUPP 16'h6A81
`define CLCH_SW_AUTH_FAIL 16'h6300
`define CLCH_SW_SEC_FAIL 16'h6982
`define CLCH_SW_BAD_P1P2 16'h6A86
`define CLCH_SW_BAD_INS 16'h6D00
`define CLCH_SW_BAD_CLA 16'h6E00
// Status byte families
`define CLCH_SW1_MORE 8'h61
`define CLCH_SW1_WARN_A 8'h62
`define CLCH_SW1_WARN_B 8'h63
// Cryptogram type field, top two bits of reference control and info data
`define CLCH_CT_MSB 7
`define CLCH_CT_LSB 6
`define CLCH_CT_DECLINED 2'b00
// Reset state
`define CLCH_RST_FLAGS 1'b0
`endif

// file: hdl/clch_pkg.sv
package clch_pkg;
  // Command kinds the card recognises
  typedef enum logic [2:0] {
    CLCH_CMD_NONE = 3'b000,
    CLCH_CMD_APP_BLOCK = 3'b001,
    CLCH_CMD_APP_UNBLOCK = 3'b010,
    CLCH_CMD_CARD_BLOCK = 3'b011,
    CLCH_CMD_SELECT = 3'b100,
    CLCH_CMD_GEN_AC = 3'b101
  } clch_cmd_t;
  // Terminal verdict on a response
  typedef enum logic [1:0] {
    CLCH_VERD_OK = 2'b00,
    CLCH_VERD_NEXT = 2'b01,
    CLCH_VERD_TERMINATE = 2'b10
  } clch_verdict_t;
endpackage

// file: hdl/clch_if.sv
`timescale 1ns/100ps
interface clch_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cla;
  logic [7:0] ins;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] lc;
  logic mac_ok;
  logic rsp_valid;
  logic [15:0] sw;
  logic rsp_has_data;
  logic [7:0] cid;
  modport card (input cmd_valid, cla, ins, p1, p2, lc, mac_ok,
    output cmd_ready, rsp_valid, sw, rsp_has_data, cid);
  modport term (output cmd_valid, cla, ins, p1, p2, lc, mac_ok,
    input cmd_ready, rsp_valid, sw, rsp_has_data, cid);
endinterface // clch_if

// file: hdl/clch_term.sv
`timescale 1ns/100ps
`include "clch_defs.svh"
module clch_term (
  input wire logic clock_in,
  input wire logic rst_b_in,
  clch_if.term link,
  input wire logic req_valid_in,
  input wire logic [7:0] req_ins_in,
  input wire logic [7:0] req_lc_in,
  input wire logic req_sm_alt_in,
  input wire logic req_script_in,
  input wire logic req_mac_ok_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [15:0] done_sw_out,
  output clch_pkg::clch_verdict_t verdict_out,
  output logic auth_failed_out
);
  logic busy;
  logic issued;
  logic [7:0] ins;
  logic [7:0] lc;
  logic sm_alt;
  logic script;
  logic mac_ok;
  logic done;
  logic [15:0] done_sw;
  clch_pkg::clch_verdict_t verdict;
  logic auth_failed;
  clch_pkg::clch_verdict_t next_verdict;

  wire logic lc_cmd = (req_ins_in == `CLCH_INS_APP_BLOCK) ||
    (req_ins_in == `CLCH_INS_APP_UNBLOCK) || (req_ins_in == `CLCH_INS_CARD_BLOCK);
  wire logic req_ok = !lc_cmd || req_script_in;
  wire logic accept = req_valid_in && !busy && req_ok;
  wire logic [7:0] sw1 = link.sw[15:8];
  wire logic sw_ok = (link.sw == `CLCH_SW_OK) || (sw1 == `CLCH_SW1_MORE);
  wire logic sw_warn = (sw1 == `CLCH_SW1_WARN_A) || (sw1 == `CLCH_SW1_WARN_B);

  assign req_ready_out = !busy;
  // Command shown for one cycle only, so the card takes it once
  assign link.cmd_valid = busy && !issued;
  assign link.ins = ins;
  assign link.lc = lc;
  assign link.cla = sm_alt ? `CLCH_CLA_SM_ALT : `CLCH_CLA_SM_MAC;
  assign link.p1 = `CLCH_P_ZERO;
  assign link.p2 = `CLCH_P_ZERO;
  assign link.mac_ok = mac_ok;
  assign done_out = done;
  assign done_sw_out = done_sw;
  assign verdict_out = verdict;
  assign auth_failed_out = auth_failed;

  // Verdict on the status returned
  always_comb begin
    if (sw_ok) begin
      next_verdict = clch_pkg::CLCH_VERD_OK;
    end else if (sw_warn && script) begin
      next_verdict = clch_pkg::CLCH_VERD_NEXT;
    end else if (ins == `CLCH_INS_SELECT && link.sw == `CLCH_SW_INVALIDATED) begin
      next_verdict = clch_pkg::CLCH_VERD_NEXT;
    end else begin
      next_verdict = clch_pkg::CLCH_VERD_TERMINATE;
    end
  end

  // One command outstanding at a time
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy <= 1'b0;
      issued <= 1'b0;
      ins <= 8'h00;
      lc <= 8'h00;
      sm_alt <= 1'b0;
      script <= 1'b0;
      mac_ok <= 1'b0;
      done <= 1'b0;
      done_sw <= 16'h0000;
      verdict <= clch_pkg::CLCH_VERD_OK;
      auth_failed <= 1'b0;
    end else begin
      done <= 1'b0;
      if (accept) begin
        busy <= 1'b1;
        issued <= 1'b0;
        ins <= req_ins_in;
        lc <= req_lc_in;
        sm_alt <= req_sm_alt_in;
        script <= req_script_in;
        mac_ok <= req_mac_ok_in;
      end else if (link.cmd_valid && link.cmd_ready) begin
        // Card took the command on this edge
        issued <= 1'b1;
      end else if (busy && link.rsp_valid) begin
        busy <= 1'b0;
        done <= 1'b1;
        done_sw <= link.sw;
        verdict <= next_verdict;
        auth_failed <= (ins == `CLCH_INS_EXT_AUTH) && (link.sw == `CLCH_SW_AUTH_FAIL);
      end
    end
  end
endmodule // clch_term

// file: verification/clch_chk_sva.sv
`timescale 1ns/100ps
`include "clch_defs.svh"
module clch_chk (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cla,
  input wire logic [7:0] ins,
  input wire logic [7:0] p1,
  input wire logic [7:0] p2,
  input wire logic [7:0] lc,
  input wire logic mac_ok,
  input wire logic rsp_valid,
  input wire logic [15:0] sw,
  input wire logic rsp_has_data,
  input wire logic [7:0] cid
);
  // Lifecycle command decode
  wire blk = cmd_valid && ins == `CLCH_INS_APP_BLOCK;
  wire unb = cmd_valid && ins == `CLCH_INS_APP_UNBLOCK;
  wire cbk = cmd_valid && ins == `CLCH_INS_CARD_BLOCK;
  wire lcy = blk || unb || cbk;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  one_cmd_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command held past one cycle");
  rsp_nodata_a: assert property (lcy |=> rsp_valid && !rsp_has_data)
    else $error("lifecycle answer late or with data");
  life_cla_a: assert property (lcy |-> cla == 8'h8C || cla == 8'h84)
    else $error("lifecycle class byte wrong");
  rsv_par_a: assert property (lcy |-> p1 == 8'h00 && p2 == 8'h00)
    else $error("lifecycle parameter nonzero");
  cid_rsv_a: assert property (rsp_valid |-> cid[5:0] == 6'h00)
    else $error("cid reserved bits set");
  mac_bad_a: assert property (lcy && !mac_ok |=> sw == 16'h6982)
    else $error("bad auth code not refused");
  blk_ok_a: assert property (blk && mac_ok |=> sw == 16'h9000)
    else $error("application block not 9000");
  unb_ok_a: assert property (unb && mac_ok |=> sw == 16'h9000)
    else $error("application unblock not 9000");
  sel_blk_a: assert property ((cbk && mac_ok) ##1 sw == 16'h9000 ##[1:60]
    (cmd_valid && ins == 8'hA4) |=> sw == 16'h6A81)
    else $error("select on blocked card not 6A81");
  // Main scenarios reached
  cov_blk_c: cover property (blk && mac_ok ##1 rsp_valid);
  cov_inv_c: cover property (cmd_valid && ins == 8'hA4 ##1 sw == 16'h6283);
  cov_gac_c: cover property (cmd_valid && ins == 8'hAE ##1 sw == 16'h9000);
endmodule // clch_chk

// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clock_in = 0, rst_b_in = 0, rv = 0, alt = 0, scr = 0, mac = 0, ld = 0, aok = 0, nvb = 0;
  logic [7:0] ins = 8'h00, lcv = 8'h08;
  logic [1:0] sel = 2'h0, typ = 2'h0;
  logic [3:0] nvi = 4'h0;
  logic [15:0] lf = 16'h0038;
  logic nw = 0;
  wire [3:0] inv;
  wire [1:0] act;
  wire [15:0] dsw;
  wire blk, nwo, rdy, dn, af;
  clch_pkg::clch_verdict_t vd;
  int n_mismatch = 0, compares = 0, cyc = 0, ma = 0, mb = 0;
  int mi[4] = '{1, 0, 1, 0};
  logic [7:0] tbl[7] = '{8'hA4, 8'hAE, 8'h1E, 8'h18, 8'h82, 8'hA4, 8'hB2};
  clch_if link ();
  clch_card #(.APP_COUNT(4)) clch_card_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link),
    .select_app_in(sel), .nv_app_inval_in(nvi), .nv_card_blocked_in(nvb), .nv_load_in(ld),
    .gen_ac_type_in(typ), .auth_ok_in(aok), .app_inval_out(inv), .card_blocked_out(blk),
    .active_app_out(act), .nv_write_out(nwo));
  clch_term clch_term_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link), .req_valid_in(rv),
    .req_ins_in(ins), .req_lc_in(lcv), .req_sm_alt_in(alt), .req_script_in(scr),
    .req_mac_ok_in(mac), .req_ready_out(rdy), .done_out(dn), .done_sw_out(dsw),
    .verdict_out(vd), .auth_failed_out(af));
  clch_chk clch_chk_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cla(link.cla), .ins(link.ins), .p1(link.p1), .p2(link.p2),
    .lc(link.lc), .mac_ok(link.mac_ok), .rsp_valid(link.rsp_valid), .sw(link.sw),
    .rsp_has_data(link.rsp_has_data), .cid(link.cid));
  // Clock
  initial forever #2 clock_in = ~clock_in;
  // Hang guard and persist pulse capture
  always @(posedge clock_in) begin
    cyc++;
    if (link.rsp_valid) nw <= nwo;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One terminal request against the model
  task automatic run(input logic [7:0] i, input logic m, input logic s);
    int k;
    logic l;
    logic [15:0] r, e;
    logic [1:0] t;
    @(posedge clock_in) #1;
    r = rnd();
    ins = i; mac = m; scr = s; alt = r[0]; sel = r[2:1]; typ = r[4:3]; aok = r[5]; lcv = r[15:8];
    chk("ready", rdy, 1);
    rv = 1;
    @(posedge clock_in) #1;
    rv = 0;
    for (k = 0; k < 8 && dn !== 1'b1; k++) @(posedge clock_in) #1;
    l = i == 8'h1E || i == 8'h18 || i == 8'h16;
    e = 16'h9000;
    t = 2'h0;
    chk("done", dn, !(l && !s));
    if (l && !s) e = 16'h0000;
    else if (l && !m) e = 16'h6982;
    else if (i == 8'h1E) mi[ma] = 1;
    else if (i == 8'h18) mi[ma] = 0;
    else if (i == 8'h16) mb = 1;
    else if (mb != 0 && (i == 8'hA4 || i == 8'hAE)) e = 16'h6A81;
    else if (i == 8'hA4) begin
      ma = sel;
      if (mi[sel] != 0) e = 16'h6283;
    end else if (i == 8'hAE) t = mi[ma] != 0 ? 2'h0 : typ;
    else if (i != 8'h82) e = 16'h6D00;
    else if (!aok) e = 16'h6300;
    if (dn === 1'b1) begin
      chk("sw", dsw, e);
      chk("cid", link.cid, {t, 6'h00});
      chk("verdict", vd, e == 16'h9000 ? clch_pkg::CLCH_VERD_OK :
        (e[15:8] == 8'h62 || e[15:8] == 8'h63) && (s || i == 8'hA4) ?
        clch_pkg::CLCH_VERD_NEXT : clch_pkg::CLCH_VERD_TERMINATE);
      chk("nvwrite", nw, l && e == 16'h9000);
      chk("authfail", af, e == 16'h6300);
    end
    chk("inval", inv, {mi[3] != 0, mi[2] != 0, mi[1] != 0, mi[0] != 0});
    chk("blocked", blk, mb);
    chk("active", act, ma);
  endtask
  // Main sequence
  initial begin
    int j;
    logic [15:0] r;
    repeat (10) @(posedge clock_in);
    #1 rst_b_in = 1;
    @(posedge clock_in) #1 nvi = 4'h5;
    ld = 1;
    @(posedge clock_in) #1 ld = 0;
    @(posedge clock_in) #1;
    chk("nvload", inv, 4'h5);
    run(8'h1E, 1, 0);
    for (j = 0; j < 40; j++) begin
      r = rnd();
      run(tbl[r % 7], r[3] | r[4], 1);
    end
    run(8'h16, 0, 1);
    run(8'h16, 1, 1);
    run(8'h16, 1, 1);
    run(8'hA4, 1, 0);
    run(8'hA4, 1, 0);
    run(8'hAE, 1, 1);
    run(8'h82, 1, 1);
    test_done();
  end
endmodule // testbench
